/* hdl/cache_state_consts.svh */
// constants for the two-level cache tag and state block
`ifndef CACHE_STATE_CONSTS_SVH
`define CACHE_STATE_CONSTS_SVH
// ==========================================
// array geometry
`define CS_PWAYS      2
`define CS_PSETS      128
`define CS_PTAG_W     20
`define CS_PDATA_N    512
`define CS_BLINES     65536
`define CS_BTAG_W     12
// ==========================================
// register byte offsets
`define CS_REG_CTRL   8'h00
`define CS_REG_ERR    8'h04
`define CS_REG_EADDR  8'h08
// ==========================================
// field positions
`define CS_CTRL_PEN   0
`define CS_CTRL_BEN   1
`define CS_ERR_DATA   0
`define CS_ERR_TAG    1
`define CS_ERR_BACK   2
`define CS_ST_D       0
`define CS_ST_S       1
`define CS_ST_V       2
`define CS_ST_P       3
// ==========================================
// reset values
`define CS_CTRL_RST   2'h0
`define CS_LFSR_RST   8'ha5
`endif

/* hdl/cache_state_pkg.sv */
// types shared by the cache tag and state block
package cache_state_pkg;
	// ==========================================
	// registered state of the block
	typedef struct packed {
		logic [1:0]  ctrl;
		logic [2:0]  err;
		logic [31:0] err_addr;
		logic [31:0] prdata;
		logic        core_ack;
		logic        core_hit;
		logic [63:0] core_rdata;
		logic        bp_done;
		logic        bp_hit;
		logic        bp_bcast;
		logic        bp_dirty;
		logic        bp_perr;
		logic [7:0]  lfsr;
	} state_type;

	typedef logic [3:0] bstat_type;
endpackage : cache_state_pkg

/* hdl/cache_state.sv */
// primary and backup cache tag, state and parity logic
`timescale 1ns/1ps
`include "cache_state_consts.svh"
module cache_state (
	input  wire logic        CLK,
	input  wire logic        RST_B,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        CORE_REQ,
	input  wire logic        CORE_WRITE,
	input  wire logic [31:3] CORE_ADDR,
	input  wire logic [63:0] CORE_WDATA,
	output logic             CORE_ACK,
	output logic             CORE_HIT,
	output logic      [63:0] CORE_RDATA,
	input  wire logic        FILL_VALID,
	input  wire logic [31:3] FILL_ADDR,
	input  wire logic [63:0] FILL_DATA,
	input  wire logic        INV_VALID,
	input  wire logic [31:5] INV_ADDR,
	input  wire logic        BPROBE_REQ,
	input  wire logic        BPROBE_WRITE,
	input  wire logic [33:6] BPROBE_ADDR,
	output logic             BPROBE_DONE,
	output logic             BPROBE_HIT,
	output logic             BPROBE_BCAST,
	output logic             BPROBE_DIRTY,
	output logic             BPROBE_PERR,
	input  wire logic        BTAG_WE,
	input  wire logic        BSTAT_WE,
	input  wire logic [33:6] BUS_ADDR,
	input  wire logic        BUS_VALID,
	input  wire logic        BUS_SHARED,
	input  wire logic        BUS_DIRTY
);
	import cache_state_pkg::*;

	// ==========================================
	// storage
	// two ways of 128 sets
	logic [20:0]     ptag   [`CS_PWAYS][`CS_PSETS];
	// four subblock valid bits per block
	logic [3:0]      pvalid [`CS_PWAYS][`CS_PSETS];
	logic [71:0]     pdata  [`CS_PWAYS][`CS_PDATA_N];
	// backup arrays stand for external rams: no reset, loaded before use
	// backup tag entry is {parity, pa[33:22]}
	logic [12:0]     btag   [`CS_BLINES];
	// status kept apart from the tag
	bstat_type       bstat  [`CS_BLINES];

	state_type       st;
	state_type       next_st;

	// ==========================================
	// combinational working signals
	logic [6:0]      c_set;
	logic [1:0]      c_qw;
	logic [19:0]     c_tag;
	logic [1:0]      c_hitw;
	logic            c_hit;
	logic            c_way;
	logic [71:0]     c_word;
	logic            c_tperr;
	logic            c_dperr;
	logic            c_wr_en;
	logic [6:0]      f_set;
	logic [1:0]      f_match;
	logic            f_way;
	logic            f_alloc;
	logic [6:0]      i_set;
	logic [1:0]      i_match;
	logic [15:0]     b_idx;
	logic [12:0]     b_tword;
	bstat_type       b_st;
	logic            b_match;
	logic            b_perr;
	logic            b_hit;
	logic            b_set_dirty;
	logic            b_live;
	logic            apb_acc;
	logic [2:0]      apb_sel;
	logic            apb_setup;
	logic            apb_map;
	logic [2:0]      err_clr;
	logic [2:0]      err_set;

	// ==========================================
	// functions
	// one parity bit per data byte
	function automatic logic [7:0] byte_par(input logic [63:0] d);
		logic [7:0] p;
		p = 8'h00;
		for (int i = 0; i < 8; i++) begin
			p[i] = ^d[i*8 +: 8];
		end
		return p;
	endfunction : byte_par

	// per-way match of a block with any subblock valid
	function automatic logic [1:0] block_match(input logic [6:0] s,
	                                           input logic [19:0] t);
		logic [1:0] m;
		m = 2'h0;
		for (int w = 0; w < `CS_PWAYS; w++) begin
			m[w] = (ptag[w][s][19:0] == t) && (pvalid[w][s] != 4'h0);
		end
		return m;
	endfunction : block_match

	// even parity over valid, shared, dirty
	function automatic bstat_type make_stat(input logic v,
	                                        input logic s,
	                                        input logic d);
		return {v ^ s ^ d, v, s, d};
	endfunction : make_stat

	// one-hot register select; unmapped offsets give zero
	function automatic logic [2:0] reg_decode(input logic [7:0] a);
		logic [2:0] sel;
		sel = 3'h0;
		if (a == `CS_REG_CTRL) begin
			sel[0] = 1'b1;
		end else if (a == `CS_REG_ERR) begin
			sel[1] = 1'b1;
		end else if (a == `CS_REG_EADDR) begin
			sel[2] = 1'b1;
		end
		return sel;
	endfunction : reg_decode

	// ==========================================
	// next state
	always_comb begin
		next_st = st;
		err_set = 3'h0;
		err_clr = 3'h0;

		// one physical path for data and instruction references
		c_set = CORE_ADDR[11:5];
		c_qw  = CORE_ADDR[4:3];
		c_tag = CORE_ADDR[31:12];
		for (int w = 0; w < `CS_PWAYS; w++) begin
			c_hitw[w] = st.ctrl[`CS_CTRL_PEN]
				&& (ptag[w][c_set][19:0] == c_tag)
				&& pvalid[w][c_set][c_qw];
		end
		c_way  = c_hitw[1];
		c_word = pdata[c_way][{c_set, c_qw}];
		// stored tag parity makes the tag even
		c_tperr = (^ptag[c_way][c_set]) && (c_hitw != 2'h0);
		c_dperr = (byte_par(c_word[63:0]) != c_word[71:64])
			&& (c_hitw != 2'h0) && !CORE_WRITE;
		c_hit = (c_hitw != 2'h0) && !c_tperr && !c_dperr;
		// write-through, no write allocate: only a hit updates the array
		c_wr_en = CORE_REQ && CORE_WRITE && c_hit && !FILL_VALID;

		// answer one cycle after every request
		next_st.core_ack = CORE_REQ;
		next_st.core_hit = CORE_REQ && c_hit;
		if (CORE_REQ && !CORE_WRITE) begin
			next_st.core_rdata = c_hit ? c_word[63:0] : 64'h0;
		end

		// flag the error and keep the first failing address
		if (CORE_REQ) begin
			err_set[`CS_ERR_TAG]  = c_tperr;
			err_set[`CS_ERR_DATA] = c_dperr;
		end

		// reuse a matching way, otherwise a random one
		f_set   = FILL_ADDR[11:5];
		f_match = block_match(f_set, FILL_ADDR[31:12]);
		f_alloc = (f_match == 2'h0);
		f_way   = f_alloc ? st.lfsr[0] : f_match[1];

		i_set   = INV_ADDR[11:5];
		i_match = block_match(i_set, INV_ADDR[31:12]);

		// 64K direct-mapped lines of 64 bytes
		b_idx   = BPROBE_ADDR[21:6];
		b_tword = btag[b_idx];
		b_st    = bstat[b_idx];
		b_match = (b_tword[11:0] == BPROBE_ADDR[33:22]);
		b_perr  = (^b_tword) || (^b_st);
		// a clear valid bit always misses
		// a disabled backup cache reports nothing about its lines
		b_live = st.ctrl[`CS_CTRL_BEN] && b_match && !b_perr
			&& b_st[`CS_ST_V];
		// read hit on match and valid
		// write hit also needs shared clear
		// unshared valid line is served locally
		b_hit = b_live && (!BPROBE_WRITE || !b_st[`CS_ST_S]);
		// write hit on unshared line turns it dirty
		b_set_dirty = BPROBE_REQ && BPROBE_WRITE && b_hit
			&& !b_st[`CS_ST_D];

		next_st.bp_done = BPROBE_REQ;
		next_st.bp_hit  = BPROBE_REQ && b_hit;
		// shared valid line needs a bus broadcast on write
		next_st.bp_bcast = BPROBE_REQ && BPROBE_WRITE && b_live
			&& b_st[`CS_ST_S];
		// dirty tells the line is newer than memory
		next_st.bp_dirty = BPROBE_REQ && b_live
			&& (b_st[`CS_ST_D] || b_set_dirty);
		next_st.bp_perr = BPROBE_REQ && st.ctrl[`CS_CTRL_BEN]
			&& b_match && b_perr;
		if (BPROBE_REQ) begin
			err_set[`CS_ERR_BACK] = st.ctrl[`CS_CTRL_BEN]
				&& b_match && b_perr;
		end

		// free-running way picker
		next_st.lfsr = {st.lfsr[6:0],
			st.lfsr[7] ^ st.lfsr[5] ^ st.lfsr[4] ^ st.lfsr[3]};

		// ==========================================
		// apb slave, zero wait states
		apb_setup = PSEL && !PENABLE;
		apb_acc   = PSEL && PENABLE;
		apb_sel = reg_decode(PADDR);
		apb_map = (apb_sel != 3'h0);
		// read data taken at setup so it stands through the access cycle
		if (apb_setup && !PWRITE) begin
			if (apb_sel[0]) begin
				next_st.prdata = {30'h0, st.ctrl};
			end else if (apb_sel[1]) begin
				next_st.prdata = {29'h0, st.err};
			end else if (apb_sel[2]) begin
				next_st.prdata = st.err_addr;
			end else begin
				next_st.prdata = 32'h0;
			end
		end
		if (apb_acc && PWRITE) begin
			if (apb_sel[0]) begin
				next_st.ctrl = PWDATA[1:0];
			end else if (apb_sel[1]) begin
				err_clr = PWDATA[2:0];
			end
		end

		// a new error wins over a clear in the same cycle
		// address locks until software clears every flag
		next_st.err = (st.err & ~err_clr) | err_set;
		if (err_set != 3'h0 && st.err == 3'h0) begin
			if (err_set[`CS_ERR_BACK] && err_set[1:0] == 2'h0) begin
				next_st.err_addr = {BPROBE_ADDR[31:6], 6'h0};
			end else begin
				next_st.err_addr = {CORE_ADDR, 3'h0};
			end
		end
	end

	// ==========================================
	// state register
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			st          <= '0;
			st.ctrl     <= `CS_CTRL_RST;
			st.lfsr     <= `CS_LFSR_RST;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================
	// subblock valid bits
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			for (int w = 0; w < `CS_PWAYS; w++) begin
				for (int s = 0; s < `CS_PSETS; s++) begin
					pvalid[w][s] <= 4'h0;
				end
			end
		end else begin
			// new allocation drops the old block's subblocks
			if (FILL_VALID) begin
				if (f_alloc) begin
					pvalid[f_way][f_set] <= 4'h1 << FILL_ADDR[4:3];
				end else begin
					pvalid[f_way][f_set][FILL_ADDR[4:3]] <= 1'b1;
				end
			end
			// external update removes the whole primary block
			// invalidate last so it overrides a same-cycle fill to a block already present; a fill that allocates the block wins
			if (INV_VALID) begin
				for (int w = 0; w < `CS_PWAYS; w++) begin
					if (i_match[w]) begin
						pvalid[w][i_set] <= 4'h0;
					end
				end
			end
		end
	end

	// ==========================================
	// arrays without reset; contents are valid only behind valid bits
	always_ff @(posedge CLK) begin
		if (FILL_VALID) begin
			// tag with its even parity bit
			if (f_alloc) begin
				ptag[f_way][f_set] <= {^FILL_ADDR[31:12], FILL_ADDR[31:12]};
			end
			// byte parity stored with the fill data
			pdata[f_way][FILL_ADDR[11:3]] <= {byte_par(FILL_DATA), FILL_DATA};
		end
		// fill takes the port; the backup copy still holds the write
		if (c_wr_en) begin
			pdata[c_way][{c_set, c_qw}] <= {byte_par(CORE_WDATA), CORE_WDATA};
		end
		// only the interface loads backup tags
		if (BTAG_WE) begin
			btag[BUS_ADDR[21:6]] <= {^BUS_ADDR[33:22], BUS_ADDR[33:22]};
		end
		// status rewritten without touching the tag
		if (b_set_dirty) begin
			bstat[b_idx] <= make_stat(1'b1, 1'b0, 1'b1);
		end
		// interface write wins over the dirty update
		// interface clears valid to invalidate a line
		if (BSTAT_WE) begin
			bstat[BUS_ADDR[21:6]] <= make_stat(BUS_VALID, BUS_SHARED, BUS_DIRTY);
		end
	end

	// ==========================================
	// outputs
	assign PRDATA       = st.prdata;
	assign PREADY       = 1'b1;
	assign PSLVERR      = apb_acc && !apb_map;
	assign CORE_ACK     = st.core_ack;
	assign CORE_HIT     = st.core_hit;
	assign CORE_RDATA   = st.core_rdata;
	assign BPROBE_DONE  = st.bp_done;
	assign BPROBE_HIT   = st.bp_hit;
	assign BPROBE_BCAST = st.bp_bcast;
	assign BPROBE_DIRTY = st.bp_dirty;
	assign BPROBE_PERR  = st.bp_perr;
endmodule : cache_state

/* sim/cache_state_checker.sv */
// concurrent checks on the core and backup probe ports of the cache block
`timescale 1ns/1ps
module cache_state_checker (
	input wire logic        CLK,
	input wire logic        RST_B,
	input wire logic        CORE_REQ,
	input wire logic        CORE_WRITE,
	input wire logic        CORE_ACK,
	input wire logic        CORE_HIT,
	input wire logic [63:0] CORE_RDATA,
	input wire logic        BPROBE_REQ,
	input wire logic        BPROBE_WRITE,
	input wire logic        BPROBE_DONE,
	input wire logic        BPROBE_HIT,
	input wire logic        BPROBE_BCAST,
	input wire logic        BPROBE_DIRTY
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);
	// ==========================================
	// core port
	core_ack_a: assert property (CORE_REQ |=> CORE_ACK)
		else $error("core request not answered next cycle");
	spur_ack_a: assert property (!CORE_REQ |=> !CORE_ACK && !CORE_HIT)
		else $error("core answer without request");
	rdata_hold_a: assert property (!(CORE_REQ && !CORE_WRITE) |=> $stable(CORE_RDATA))
		else $error("read data moved without a read");
	// ==========================================
	// backup probe port
	probe_done_a: assert property (BPROBE_REQ |=> BPROBE_DONE)
		else $error("probe not answered next cycle");
	probe_idle_a: assert property (!BPROBE_DONE |-> !(BPROBE_HIT || BPROBE_BCAST || BPROBE_DIRTY))
		else $error("probe results without probe");
	hit_excl_a: assert property (BPROBE_DONE && BPROBE_HIT |-> !BPROBE_BCAST)
		else $error("hit and broadcast together");
	wr_dirty_a: assert property (BPROBE_REQ && BPROBE_WRITE ##1 BPROBE_HIT |-> BPROBE_DIRTY)
		else $error("write hit left line clean");
	read_nobc_a: assert property (BPROBE_REQ && !BPROBE_WRITE |=> !BPROBE_BCAST)
		else $error("read probe asked for broadcast");
	cover property (CORE_ACK && CORE_HIT);
	cover property (BPROBE_DONE && BPROBE_BCAST);
	cover property (BPROBE_DONE && BPROBE_HIT && BPROBE_DIRTY);
endmodule : cache_state_checker

bind cache_state cache_state_checker chk (.CLK(CLK), .RST_B(RST_B), .CORE_REQ(CORE_REQ),
	.CORE_WRITE(CORE_WRITE), .CORE_ACK(CORE_ACK), .CORE_HIT(CORE_HIT),
	.CORE_RDATA(CORE_RDATA), .BPROBE_REQ(BPROBE_REQ), .BPROBE_WRITE(BPROBE_WRITE),
	.BPROBE_DONE(BPROBE_DONE), .BPROBE_HIT(BPROBE_HIT), .BPROBE_BCAST(BPROBE_BCAST),
	.BPROBE_DIRTY(BPROBE_DIRTY));

/* sim/bus_side_model.sv */
// model of the bus interface side: fills, invalidates, backup tag and status loads
`timescale 1ns/1ps
module bus_side_model (
	input  wire logic        clk,
	output logic             fill_valid,
	output logic      [31:3] fill_addr,
	output logic      [63:0] fill_data,
	output logic             inv_valid,
	output logic      [31:5] inv_addr,
	output logic             btag_we,
	output logic             bstat_we,
	output logic      [33:6] bus_addr,
	output logic             bus_valid,
	output logic             bus_shared,
	output logic             bus_dirty
);
	initial begin
		{fill_valid, inv_valid, btag_we, bstat_we, bus_valid, bus_shared, bus_dirty} = '0;
		{fill_addr, fill_data, inv_addr, bus_addr} = '0;
	end
	// ==========================================
	// primary side; released lines show the inverse, not the last value
	task automatic fill(input logic [31:3] a, input logic [63:0] dat);
		fill_valid <= 1'b1;
		fill_addr <= a;
		fill_data <= dat;
		@(posedge clk);
		fill_valid <= 1'b0;
		fill_addr <= ~a;
		fill_data <= ~dat;
	endtask : fill
	task automatic invalidate(input logic [31:5] a);
		inv_valid <= 1'b1;
		inv_addr <= a;
		@(posedge clk);
		inv_valid <= 1'b0;
		inv_addr <= ~a;
	endtask : invalidate
	// ==========================================
	// backup side
	// tag and status loads
	task automatic load_line(input logic [33:6] a, input logic tag, input logic vv, ss, dd);
		btag_we <= tag;
		bstat_we <= 1'b1;
		bus_addr <= a;
		{bus_valid, bus_shared, bus_dirty} <= {vv, ss, dd};
		@(posedge clk);
		{btag_we, bstat_we} <= 2'b00;
		bus_addr <= ~a;
		{bus_valid, bus_shared, bus_dirty} <= ~{vv, ss, dd};
	endtask : load_line
endmodule : bus_side_model

/* sim/testbench.sv */
// self-checking testbench for the cache tag and state block
`timescale 1ns/1ps
`include "cache_state_consts.svh"
module testbench;
	import cache_state_pkg::*;
	localparam logic [31:3] A = {20'h12345, 7'h11, 2'h0};
	localparam logic [31:3] B = {20'h12344, 7'h11, 2'h0};
	localparam logic [31:3] C = {20'h54321, 7'h11, 2'h0};
	localparam logic [33:6] L = {12'h5a3, 16'h0123};
	localparam logic [33:6] M = {12'h5a2, 16'h0123};
	localparam logic [63:0] D0 = 64'h0123456789abcdef, D1 = 64'hfedcba9876543210;
	localparam logic [63:0] D2 = 64'h5555aaaa0f0f3c3c, D3 = 64'h0000ffff1234abcd;
	logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, e, v, s, d;
	logic        core_req, core_write, core_ack, core_hit, fill_valid, inv_valid;
	logic        btag_we, bstat_we, bus_valid, bus_shared, bus_dirty, bprobe_req;
	logic        bprobe_write, bprobe_done, bprobe_hit, bprobe_bcast, bprobe_dirty, bprobe_perr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [31:3] core_addr, fill_addr;
	logic [31:5] inv_addr;
	logic [33:6] bprobe_addr, bus_addr;
	logic [63:0] core_wdata, core_rdata, fill_data;
	int          bad_count, total_checks;

	always #20 clk = ~clk;

	cache_state dut (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.CORE_REQ(core_req), .CORE_WRITE(core_write), .CORE_ADDR(core_addr),
		.CORE_WDATA(core_wdata), .CORE_ACK(core_ack), .CORE_HIT(core_hit),
		.CORE_RDATA(core_rdata), .FILL_VALID(fill_valid), .FILL_ADDR(fill_addr),
		.FILL_DATA(fill_data), .INV_VALID(inv_valid), .INV_ADDR(inv_addr),
		.BPROBE_REQ(bprobe_req), .BPROBE_WRITE(bprobe_write), .BPROBE_ADDR(bprobe_addr),
		.BPROBE_DONE(bprobe_done), .BPROBE_HIT(bprobe_hit), .BPROBE_BCAST(bprobe_bcast),
		.BPROBE_DIRTY(bprobe_dirty), .BPROBE_PERR(bprobe_perr), .BTAG_WE(btag_we),
		.BSTAT_WE(bstat_we), .BUS_ADDR(bus_addr), .BUS_VALID(bus_valid),
		.BUS_SHARED(bus_shared), .BUS_DIRTY(bus_dirty));

	bus_side_model bus_side (.clk(clk), .fill_valid(fill_valid), .fill_addr(fill_addr),
		.fill_data(fill_data), .inv_valid(inv_valid), .inv_addr(inv_addr), .btag_we(btag_we),
		.bstat_we(bstat_we), .bus_addr(bus_addr), .bus_valid(bus_valid),
		.bus_shared(bus_shared), .bus_dirty(bus_dirty));

	// ==========================================
	// compares and closing
	task automatic chk_word(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_word
	task automatic chk_bit(input logic got, input logic exp);
		chk_word({63'h0, got}, {63'h0, exp});
	endtask : chk_bit
	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test
	// ==========================================
	// port tasks, entered just after a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 8);
		if (pready !== 1'b1) begin
			bad_count++;
			end_of_test();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			pwdata <= ~wd;
			// idle edge: a following call never drives psel twice at once
			@(posedge clk);
		end
	endtask : apb
	task automatic core_op(input logic wr, input logic [31:3] a, input logic [63:0] wd,
			input logic hit, input logic [63:0] rd);
		core_req <= 1'b1;
		core_write <= wr;
		core_addr <= a;
		core_wdata <= wd;
		@(posedge clk);
		core_req <= 1'b0;
		core_wdata <= ~wd;
		#1;
		chk_bit(core_ack, 1'b1);
		chk_bit(core_hit, hit);
		if (!wr)
			chk_word(core_rdata, rd);
		@(posedge clk);
	endtask : core_op
	task automatic probe(input logic wr, input logic [33:6] a, input logic hit, bc, dy, cd);
		bprobe_req <= 1'b1;
		bprobe_write <= wr;
		bprobe_addr <= a;
		@(posedge clk);
		bprobe_req <= 1'b0;
		bprobe_addr <= ~a;
		#1;
		chk_bit(bprobe_done, 1'b1);
		chk_bit(bprobe_hit, hit);
		chk_bit(bprobe_bcast, bc);
		chk_bit(bprobe_perr, 1'b0);
		if (cd)
			chk_bit(bprobe_dirty, dy);
		@(posedge clk);
	endtask : probe
	// ==========================================
	// main sequence
	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		{psel, penable, pwrite, core_req, core_write, bprobe_req, bprobe_write} = '0;
		{paddr, pwdata, core_addr, core_wdata, bprobe_addr} = '0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, 8'(4 * i), '0, q, e);
			chk_word({32'h0, q}, '0);
			chk_bit(e, 1'b0);
		end
		apb(1'b0, 8'h40, '0, q, e);
		chk_bit(e, 1'b1);
		$display("register test done");
		bus_side.fill(A, D0);
		core_op(1'b0, A, '0, 1'b0, '0);
		apb(1'b1, `CS_REG_CTRL, 32'h1, q, e);
		core_op(1'b0, A, '0, 1'b1, D0);
		core_op(1'b0, A + 29'h1, '0, 1'b0, '0);
		bus_side.fill(A + 29'h1, D1);
		core_op(1'b0, A, '0, 1'b1, D0);
		core_op(1'b0, B, '0, 1'b0, '0);
		core_op(1'b1, A, D2, 1'b1, '0);
		core_op(1'b1, B, D3, 1'b0, '0);
		core_op(1'b0, B, '0, 1'b0, '0);
		core_req <= 1'b1;
		core_write <= 1'b0;
		core_addr <= A;
		@(posedge clk);
		core_addr <= A + 29'h1;
		#1;
		chk_word(core_rdata, D2);
		@(posedge clk);
		core_req <= 1'b0;
		#1;
		chk_word(core_rdata, D1);
		@(posedge clk);
		bus_side.invalidate(A[31:5]);
		core_op(1'b0, A + 29'h1, '0, 1'b0, '0);
		bus_side.fill(C, D3);
		core_op(1'b0, C, '0, 1'b1, D3);
		$display("primary cache test done");
		bus_side.load_line(L, 1'b1, 1'b1, 1'b0, 1'b0);
		probe(1'b1, L, 1'b0, 1'b0, 1'b0, 1'b1);
		apb(1'b1, `CS_REG_CTRL, 32'h3, q, e);
		apb(1'b0, `CS_REG_CTRL, '0, q, e);
		chk_word({32'h0, q}, 64'h3);
		probe(1'b0, M, 1'b0, 1'b0, 1'b0, 1'b0);
		for (int i = 0; i < 8; i++) begin
			{v, s, d} = 3'(i);
			bus_side.load_line(L, 1'b0, v, s, d);
			probe(1'b0, L, v, 1'b0, d, v);
			probe(1'b1, L, v & !s, v & s, d | (v & !s), v);
			probe(1'b0, L, v, 1'b0, d | (v & !s), v);
		end
		apb(1'b0, `CS_REG_ERR, '0, q, e);
		chk_word({32'h0, q}, '0);
		$display("backup cache test done");
		end_of_test();
	end
endmodule : testbench
